// ### switch_pkg.sv
// Package: widths, timing constants and carrier structs for the octal switch logic
package switch_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int NUM_OUT       = 8;
   localparam int WORD_BITS     = 16;
   localparam int EXTRA_STEP    = 8;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ        = 50_000_000;
   localparam int FILTER_MIN_US = 100;
   localparam int FILTER_MAX_US = 300;
   // Least time, no rounding up
   localparam int FILTER_CYCLES = (FILTER_MIN_US * (CLK_HZ / 1_000_000) + 0);

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [NUM_OUT-1:0] OUT_RST   = 8'h00;
   localparam logic [NUM_OUT-1:0] SENSE_RST = 8'h00;
   localparam logic [4:0]         CNT_RST   = 5'h00;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [NUM_OUT-1:0] sense_en;
      logic [NUM_OUT-1:0] out_on;
   } cmd_word_t;

   typedef struct packed {
      logic [NUM_OUT-1:0] thermal_limit;
      logic [NUM_OUT-1:0] over_current;
      logic [NUM_OUT-1:0] below_open_load_threshold;
   } sense_in_t;

endpackage : switch_pkg

// ### sync2.sv
// Two-flop synchroniser, one bit per lane
`timescale 1ns/100ps
module sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_ff <= '0;
         q       <= '0;
      end
      else
      begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule : sync2

// ### octal_switch_spi_fault_logic.sv
// Octal power switch: SPI command and status, fault logic, shutdown control
// How it works
// - Over-temperature output reads one in status
// - Off open load flagged only with sense
// - Over-voltage turns all off, restores afterwards
// - Overheat affects one output, restores command
// - Command bits 0-7 switch outputs on
// - Command bits 8-15 enable sense currents
// - Status bits 0-7 report per-output faults
// - Sleep resets to all off, sense off
// - Status shifts out while command shifts in
// - No fault gives zeros, faults give ones
// - 32-bit transfer echoes first sixteen bits
// - Last sixteen bits applied at select rise
// - Only 16 plus multiples of 8 accepted
// - Thermal shutdown independent, auto re-activates
// - Sense current programmable, off after reset
// - Select rise starts open-load mask timer
// - Open load stays latched until read
// - Per-output comparator, flagged only when off
// - Short cycles thermal shutdown until removed
// - Shorts reported regardless of sense enables
// - Both words shifted MSB first, FIFO
// - Status bits 8-15 always zero
`timescale 1ns/100ps
module octal_switch_spi_fault_logic
   import switch_pkg::*;
#(
   parameter int NOUT          = switch_pkg::NUM_OUT,
   parameter int FILTER_CYCLES = switch_pkg::FILTER_CYCLES
) (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // Power and enable
   input  wire logic                     enable,
   input  wire logic                     logic_supply_ok,
   input  wire logic                     supply_overvoltage,
   // SPI pins
   input  wire logic                     cs_n,
   input  wire logic                     sclk,
   input  wire logic                     mosi,
   output logic                          miso,
   output logic                          miso_oe_n,
   // Analog sense inputs
   input  switch_pkg::sense_in_t         sense,
   // Outputs to drivers
   output logic [switch_pkg::NUM_OUT-1:0] gate_on,
   output logic [switch_pkg::NUM_OUT-1:0] sense_current_on,
   output logic [switch_pkg::NUM_OUT-1:0] status_flags
);
   import switch_pkg::*;

   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------
   localparam int NSYNC = 3 + 2 + 3 * NUM_OUT;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] syn_in;
   logic             cs_n_s;
   logic             cs_act_s;
   logic             sclk_s;
   logic             mosi_s;
   logic             awake_s;
   logic             ov_s;
   sense_in_t        sense_s;

   // Select lane inverted so the cleared flop reads as deselected
   assign raw_in = {!cs_n, sclk, mosi, enable & logic_supply_ok, supply_overvoltage, sense};

   sync2 #(.W(NSYNC)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (raw_in),
      .q     (syn_in)
   );

   assign {cs_act_s, sclk_s, mosi_s, awake_s, ov_s, sense_s} = syn_in;
   assign cs_n_s = !cs_act_s;

   // ---------------------------------------------------------------
   // Edge detection
   // ---------------------------------------------------------------
   logic cs_n_d_ff;
   logic sclk_d_ff;
   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic sleep;

   assign sleep = !awake_s;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cs_n_d_ff <= 1'b1;
         sclk_d_ff <= 1'b0;
      end
      else
      begin
         cs_n_d_ff <= cs_n_s;
         sclk_d_ff <= sclk_s;
      end
   end

   assign cs_fall   = cs_n_d_ff & !cs_n_s;
   assign cs_rise   = !cs_n_d_ff & cs_n_s;
   assign sclk_rise = !cs_n_s & !sclk_d_ff & sclk_s;
   assign sclk_fall = !cs_n_s & sclk_d_ff & !sclk_s;

   // ---------------------------------------------------------------
   // Pulse counter: acceptance needs the counter at 16, i.e. 16 plus any multiple of 8 pulses
   // ---------------------------------------------------------------
   logic [4:0] pulse_cnt_ff;
   logic       count_ok;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pulse_cnt_ff <= CNT_RST;
      else if (cs_fall)
         pulse_cnt_ff <= CNT_RST;
      else if (sclk_rise)
      begin
         // Count up to 23, then wrap back to 16 in steps of 8
         if (pulse_cnt_ff == 5'h17)
            pulse_cnt_ff <= 5'h10;
         else
            pulse_cnt_ff <= pulse_cnt_ff + 5'h01;
      end
   end

   assign count_ok = (pulse_cnt_ff == 5'h10);

   // ---------------------------------------------------------------
   // Shift register
   // ---------------------------------------------------------------
   logic [WORD_BITS-1:0] shift_ff;
   logic [NOUT-1:0]      fault_now;
   logic [NOUT-1:0]      open_latch_ff;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         shift_ff <= '0;
      else if (sleep)
         shift_ff <= '0;
      else if (cs_fall)
         shift_ff <= {8'h00, fault_now | open_latch_ff};
      else if (sclk_rise)
         shift_ff <= {shift_ff[WORD_BITS-2:0], mosi_s};
   end

   // MSB presented on MISO, changes after falling SCLK
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         miso <= 1'b0;
      else if (cs_fall || sclk_fall)
         miso <= cs_fall ? 1'b0 : shift_ff[WORD_BITS-1];
   end

   assign miso_oe_n = cs_n_s;

   // ---------------------------------------------------------------
   // Command register
   // ---------------------------------------------------------------
   cmd_word_t cmd_ff;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_ff.out_on   <= OUT_RST;
         cmd_ff.sense_en <= SENSE_RST;
      end
      else if (sleep)
      begin
         cmd_ff.out_on   <= OUT_RST;
         cmd_ff.sense_en <= SENSE_RST;
      end
      else if (cs_rise && count_ok)
         cmd_ff <= cmd_word_t'(shift_ff);
   end

   assign sense_current_on = cmd_ff.sense_en;

   // ---------------------------------------------------------------
   // Fault filter timer
   // ---------------------------------------------------------------
   localparam int TW = $clog2(FILTER_CYCLES + 1);
   logic [TW-1:0] filt_cnt_ff;
   logic          filt_done;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         filt_cnt_ff <= '0;
      else if (cs_rise || sleep)
         filt_cnt_ff <= TW'(FILTER_CYCLES);
      else if (filt_cnt_ff != '0)
         filt_cnt_ff <= filt_cnt_ff - TW'(1);
   end

   assign filt_done = (filt_cnt_ff == '0);

   // ---------------------------------------------------------------
   // Per-output fault and gate logic
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_OUT; g++)
      begin : g_out
         logic open_now;
         // Off-state open load: commanded off, sense on, mask expired
         assign open_now = !cmd_ff.out_on[g] & cmd_ff.sense_en[g]
                           & sense_s.below_open_load_threshold[g] & filt_done;
         // On-state short, or overheat in any state, independent of sense enable
         assign fault_now[g] = open_now
                             | (cmd_ff.out_on[g] & sense_s.over_current[g])
                             | sense_s.thermal_limit[g];

         // Latch held until captured for read; new event wins over clear
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               open_latch_ff[g] <= 1'b0;
            else if (sleep)
               open_latch_ff[g] <= 1'b0;
            else if (open_now)
               open_latch_ff[g] <= 1'b1;
            else if (cs_fall)
               open_latch_ff[g] <= 1'b0;
         end

         // Thermal shutdown gates this output only; command kept
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               gate_on[g] <= 1'b0;
            else
               gate_on[g] <= cmd_ff.out_on[g] & !sense_s.thermal_limit[g]
                             & !ov_s & !sleep;
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Status mirror
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         status_flags <= '0;
      else
         status_flags <= fault_now | open_latch_ff;
   end

endmodule : octal_switch_spi_fault_logic

// ### octal_switch_chk.sv
// Checker: port-level timing relations of the octal switch logic
`timescale 1ns/100ps
module octal_switch_chk
   import switch_pkg::*;
(
   // Clock, reset, power
   input wire logic                        clk,
   input wire logic                        rst_n,
   input wire logic                        enable,
   input wire logic                        logic_supply_ok,
   input wire logic                        supply_overvoltage,
   // Select and data enable
   input wire logic                        cs_n,
   input wire logic                        miso_oe_n,
   // Sense and outputs
   input wire switch_pkg::sense_in_t       sense,
   input wire logic [switch_pkg::NUM_OUT-1:0] gate_on,
   input wire logic [switch_pkg::NUM_OUT-1:0] sense_current_on,
   input wire logic [switch_pkg::NUM_OUT-1:0] status_flags
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_still;
      ($stable(sense))[*4];
   endsequence
   sequence s_calm;
      ($stable(sense) && $stable(gate_on))[*4];
   endsequence
   property p_sleep;
      !(enable && logic_supply_ok) |-> ##[1:4] (gate_on == 8'h00 && sense_current_on == 8'h00);
   endproperty
   a_sleep: assert property (p_sleep) else $error("outputs live in sleep");
   property p_ov;
      $rose(supply_overvoltage) |-> ##[1:4] gate_on == 8'h00;
   endproperty
   a_ov: assert property (p_ov) else $error("output on during over-voltage");
   property p_hot_off;
      s_still |-> (gate_on & sense.thermal_limit) == 8'h00;
   endproperty
   a_hot_off: assert property (p_hot_off) else $error("hot output on");
   property p_hot_flag;
      s_still |-> (status_flags & sense.thermal_limit) == sense.thermal_limit;
   endproperty
   a_hot_flag: assert property (p_hot_flag) else $error("hot output not flagged");
   property p_short_flag;
      s_calm |-> (status_flags & gate_on & sense.over_current) == (gate_on & sense.over_current);
   endproperty
   a_short_flag: assert property (p_short_flag) else $error("short not flagged");
   property p_oe_off;
      cs_n [*4] |-> miso_oe_n;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("data out driven while idle");
   property p_oe_on;
      (!cs_n) [*4] |-> !miso_oe_n;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("data out not driven");
   property p_hold_gate;
      (!cs_n && enable && logic_supply_ok && !supply_overvoltage && $stable(sense)) [*4]
         |-> $stable(gate_on);
   endproperty
   a_hold_gate: assert property (p_hold_gate) else $error("gate moved in frame");
   property p_hold_sense;
      (!cs_n && enable && logic_supply_ok) [*4] |-> $stable(sense_current_on);
   endproperty
   a_hold_sense: assert property (p_hold_sense) else $error("sense moved in frame");
endmodule : octal_switch_chk

// ### spi_host.sv
// Host model: SPI master frames and received word
`timescale 1ns/100ps
module spi_host (
   // Clock
   input  wire logic        clk,
   // SPI pins
   output logic             cs_n,
   output logic             sclk,
   output logic             mosi,
   input  wire logic        miso,
   // Result
   output logic [31:0]      rd,
   output logic             done
);
   initial {cs_n, sclk, mosi, rd, done} = {3'h4, 32'h0, 1'h0};
   task automatic wt(input int n);
      repeat (n) @(posedge clk) #1;
   endtask : wt
   task automatic xfer(input int n, input logic [31:0] d);
      rd = 32'h0;
      cs_n = 1'h0;
      wt(8);
      for (int i = n - 1; i >= 0; i--)
      begin
         mosi = d[i];
         wt(4);
         sclk = 1'h1;
         rd = {rd[30:0], miso};
         wt(4);
         sclk = 1'h0;
      end
      wt(4);
      cs_n = 1'h1;
      mosi = ~mosi;
      wt(12);
      done = 1'h1;
      wt(1);
      done = 1'h0;
      wt(400);
   endtask : xfer
endmodule : spi_host

// ### octal_switch_spi_fault_logic_tb_top.sv
// Testbench top: host frames, fault stimulus, scoreboard
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
   $display("unexpected %0t got %h exp %h", $time, a, e); end end
module octal_switch_spi_fault_logic_tb_top;
   import switch_pkg::*;
   logic clk = 1'h0, rst_n = 1'h0, enable = 1'h1, logic_supply_ok = 1'h1;
   logic supply_overvoltage = 1'h0;
   logic cs_n, sclk, mosi, miso, miso_oe_n, done;
   sense_in_t sense = '0;
   logic [7:0] gate_on, sense_current_on, status_flags;
   logic [7:0] cmd_g = 8'h00, cmd_s = 8'h00, open_exp = 8'h00;
   int lens[3] = '{15, 17, 24};
   logic [31:0] rd;
   logic [47:0] q[$];
   logic [47:0] e;
   int num_errors = 0, n_checks = 0, cyc = 0;
   always #10 clk = ~clk;
   spi_host u_spi_host (.clk, .cs_n, .sclk, .mosi, .miso, .rd, .done);
   octal_switch_spi_fault_logic #(.FILTER_CYCLES(20)) u_octal_switch_spi_fault_logic (
      .clk, .rst_n, .enable, .logic_supply_ok, .supply_overvoltage, .cs_n, .sclk, .mosi,
      .miso, .miso_oe_n, .sense, .gate_on, .sense_current_on, .status_flags);
   function automatic logic [31:0] stream(input int n, input logic [7:0] st, input logic [31:0] d);
      logic [47:0] s;
      s = {8'h00, st, 32'h0} | (48'(d) << (32 - n));
      return 32'(s >> (48 - n));
   endfunction : stream
   task automatic send(input int n, input logic [31:0] d, input logic [7:0] st);
      logic [31:0] m;
      m = d & 32'((64'h1 << n) - 1);
      if (n >= 16 && n % 8 == 0)
      begin
         cmd_g = m[7:0];
         cmd_s = m[15:8];
      end
      q.push_back({stream(n, st, m), cmd_g & ~sense.thermal_limit, cmd_s});
      u_spi_host.xfer(n, m);
   endtask : send
   task automatic finish_test();
      if (num_errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   always @(posedge clk)
      if (done === 1'h1)
      begin
         e = q.pop_front();
         `CHK({rd, gate_on, sense_current_on}, e)
      end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         finish_test();
      end
   end
   initial
   begin
      void'($urandom(36673));
      repeat (10) @(posedge clk);
      #1 rst_n = 1'h1;
      u_spi_host.wt(3);
      send(32, $urandom(), 8'h00);
      repeat (3) send(16, $urandom(), 8'h00);
      foreach (lens[i]) send(lens[i], $urandom(), 8'h00);
      send(16, 32'h0F00, 8'h00);
      sense.below_open_load_threshold = 8'hFF;
      u_spi_host.wt(40);
      send(16, 32'h0F00, 8'h0F);
      `CHK(status_flags & ~cmd_g, 8'h0F)
      sense.below_open_load_threshold = 8'h00;
      send(16, 32'h0F00, 8'h0F);
      send(16, 32'h0F00, 8'h00);
      sense.over_current = 8'h30;
      sense.thermal_limit = 8'h01;
      send(16, 32'h00F1, 8'h01);
      send(16, 32'h00F1, 8'h31);
      `CHK(status_flags & cmd_g, 8'h31)
      sense = '0;
      u_spi_host.wt(10);
      send(15, 32'h0, 8'h00);
      supply_overvoltage = 1'h1;
      u_spi_host.wt(10);
      supply_overvoltage = 1'h0;
      u_spi_host.wt(10);
      send(8, 32'h0, 8'h00);
      for (int k = 0; k < 4; k++)
      begin
         send(16, $urandom(), open_exp);
         sense = 24'($urandom());
         u_spi_host.wt(10);
         open_exp = ~cmd_g & cmd_s & sense.below_open_load_threshold;
         `CHK(status_flags, sense.thermal_limit | (cmd_g & sense.over_current) | open_exp)
         `CHK(gate_on, cmd_g & ~sense.thermal_limit)
         sense = '0;
         u_spi_host.wt(10);
         `CHK(status_flags, open_exp)
      end
      for (int k = 0; k < 2; k++)
      begin
         send(16, $urandom() | 32'h0101, k ? 8'h00 : open_exp);
         {enable, logic_supply_ok} = k ? 2'h2 : 2'h1;
         u_spi_host.wt(10);
         {enable, logic_supply_ok} = 2'h3;
         cmd_g = 8'h00;
         cmd_s = 8'h00;
         u_spi_host.wt(10);
         send(8, 32'h0, 8'h00);
      end
      finish_test();
   end
endmodule : octal_switch_spi_fault_logic_tb_top
bind octal_switch_spi_fault_logic octal_switch_chk u_octal_switch_chk (.clk, .rst_n, .enable,
   .logic_supply_ok, .supply_overvoltage, .cs_n, .miso_oe_n, .sense, .gate_on,
   .sense_current_on, .status_flags);
